// ==== rx_telecom_bus_input.sv ====
// Receive telecom bus input: link sampling, parity, path alarm and APB registers
//
// Functional notes
// - Every bus input is sampled on the falling edge of the bus clock.
// - Marker pin meaning follows bus enable and payload APS enable.
// - Parity may cover the eight data bits only, even or odd.
// - Parity may also cover payload indicator and marker, even or odd.
// - Coverage and sense come from the bus control register.
// - Alarm high for a payload byte declares path AIS for that STS-1.
// - One byte is latched per falling edge from the 8-bit bus.
// - Payload APS role allowed only outside the aggregation role.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "rx_tbus_consts.svh"
module rx_telecom_bus_input #(
	parameter int PERR_CNT_WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_bus_clock,
	input wire logic [7:0] rx_data_byte,
	input wire logic rx_payload_indicator,
	input wire logic rx_frame_phase_marker,
	input wire logic rx_bus_parity,
	input wire logic rx_alarm,
	output logic [7:0] byte_out,
	output logic byte_strobe,
	output logic byte_is_payload,
	output logic byte_phase_marker,
	output logic [1:0] byte_sts1_index,
	output logic [2:0] ais_defect,
	output logic aps_role_active,
	output logic irq
);

	// ======================================================================
	// Pin synchronisers
	// The clock pin is just another pin here; at 10 MHz against 19.44 MHz
	// edges are lost, so the bench runs the link clock at 800 ns.
	logic clk_level;
	rx_tbus_pkg::bus_sample_t pin_raw;
	rx_tbus_pkg::bus_sample_t sample;

	always_comb begin
		pin_raw.data = rx_data_byte;
		pin_raw.payload = rx_payload_indicator;
		pin_raw.marker = rx_frame_phase_marker;
		pin_raw.parity = rx_bus_parity;
		pin_raw.alarm = rx_alarm;
	end

	link_sync #(
		.WIDTH(1)
	) u_clk_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.raw(rx_bus_clock),
		.level(clk_level)
	);

	// Same latency as the clock path keeps data aligned to the edge
	link_sync #(
		.WIDTH($bits(rx_tbus_pkg::bus_sample_t))
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.raw(pin_raw),
		.level(sample)
	);

	// ======================================================================
	// Control state
	rx_tbus_pkg::ctrl_t ctrl;
	rx_tbus_pkg::ctrl_t next_ctrl;
	rx_tbus_pkg::ctrl_t wr_ctrl;
	logic bus_active;
	logic parity_mismatch;

	// Marker is a phase marker only while the telecom bus role is live
	assign bus_active = ctrl.bus_enable & ~ctrl.aps_enable;

	bus_parity_check u_parity (
		.sample(sample),
		.parity_full(ctrl.parity_full),
		.parity_odd(ctrl.parity_odd),
		.mismatch(parity_mismatch)
	);

	// ======================================================================
	// Link capture and STS-1 interleave
	logic clk_level_d;
	logic clk_fall;
	rx_tbus_pkg::align_t align;
	rx_tbus_pkg::align_t next_align;
	logic [1:0] sts_idx;
	logic [1:0] next_sts_idx;
	logic [1:0] next_byte_sts1_index;
	logic [7:0] next_byte_out;
	logic next_byte_strobe;
	logic next_byte_is_payload;
	logic next_byte_phase_marker;
	logic [2:0] next_ais_defect;
	logic ev_parity;
	logic ev_frame;
	logic ev_ais;

	assign clk_fall = clk_level_d & ~clk_level;

	always_comb begin
		next_align = align;
		next_sts_idx = sts_idx;
		next_byte_out = byte_out;
		next_byte_strobe = 1'b0;
		next_byte_is_payload = byte_is_payload;
		next_byte_phase_marker = byte_phase_marker;
		next_byte_sts1_index = byte_sts1_index;
		next_ais_defect = ais_defect;
		ev_parity = 1'b0;
		ev_frame = 1'b0;
		ev_ais = 1'b0;
		if (!bus_active) begin
			// Defects are meaningless once the bus is off
			next_align = rx_tbus_pkg::ALIGN_HUNT;
			next_ais_defect = 3'h0;
		end else if (clk_fall) begin
			next_byte_out = sample.data;
			next_byte_strobe = 1'b1;
			next_byte_is_payload = sample.payload;
			next_byte_phase_marker = sample.marker;
			ev_parity = parity_mismatch;
			if (sample.marker && !sample.payload) begin
				// C1/J0 belongs to the first STS-1 and restarts the interleave
				next_align = rx_tbus_pkg::ALIGN_LOCKED;
				ev_frame = 1'b1;
				next_byte_sts1_index = 2'h0;
				next_sts_idx = 2'h1;
			end else if (align == rx_tbus_pkg::ALIGN_LOCKED) begin
				next_byte_sts1_index = sts_idx;
				if (sts_idx == `RX_TBUS_STS1_COUNT - 2'h1) begin
					next_sts_idx = 2'h0;
				end else begin
					next_sts_idx = sts_idx + 2'h1;
				end
				if (sample.payload) begin
					// Each payload byte refreshes its own STS-1 defect
					next_ais_defect[sts_idx] = sample.alarm;
					ev_ais = sample.alarm & ~ais_defect[sts_idx];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clk_level_d <= 1'b0;
			align <= rx_tbus_pkg::ALIGN_HUNT;
			sts_idx <= 2'h0;
			byte_out <= 8'h00;
			byte_strobe <= 1'b0;
			byte_is_payload <= 1'b0;
			byte_phase_marker <= 1'b0;
			byte_sts1_index <= 2'h0;
			ais_defect <= 3'h0;
		end else begin
			clk_level_d <= clk_level;
			align <= next_align;
			sts_idx <= next_sts_idx;
			byte_out <= next_byte_out;
			byte_strobe <= next_byte_strobe;
			byte_is_payload <= next_byte_is_payload;
			byte_phase_marker <= next_byte_phase_marker;
			byte_sts1_index <= next_byte_sts1_index;
			ais_defect <= next_ais_defect;
		end
	end

	// ======================================================================
	// APB slave and registers
	logic [3:0] status;
	logic [3:0] next_status;
	logic [3:0] mask;
	logic [3:0] next_mask;
	logic [3:0] events;
	logic [3:0] w1c;
	logic [PERR_CNT_WIDTH-1:0] perr_cnt;
	logic [PERR_CNT_WIDTH-1:0] next_perr_cnt;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_aps_role_active;
	logic next_irq;
	logic wr_take;
	logic addr_hit;
	logic ev_aps_refused;

	// A write takes effect only at the edge that completes the access
	assign wr_take = psel & penable & pready & pwrite;

	always_comb begin
		next_ctrl = ctrl;
		next_mask = mask;
		next_perr_cnt = perr_cnt;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		addr_hit = 1'b1;
		w1c = 4'h0;
		ev_aps_refused = 1'b0;
		wr_ctrl = rx_tbus_pkg::ctrl_t'(pwdata[7:0] & `RX_TBUS_CTRL_WR_MASK);
		// One wait cycle, then the answer
		next_pready = psel & penable & ~pready;
		case (paddr[11:2])
			`RX_TBUS_CTRL_IDX: begin
				next_prdata = {24'h00_0000, ctrl};
			end
			`RX_TBUS_STATUS_IDX: begin
				next_prdata = {28'h000_0000, status};
			end
			`RX_TBUS_MASK_IDX: begin
				next_prdata = {28'h000_0000, mask};
			end
			`RX_TBUS_AIS_IDX: begin
				next_prdata = {28'h000_0000, 1'b0, ais_defect};
			end
			`RX_TBUS_BYTE_IDX: begin
				next_prdata = {16'h0000, 3'h0, align == rx_tbus_pkg::ALIGN_LOCKED,
					byte_sts1_index, byte_is_payload, byte_phase_marker, byte_out};
			end
			`RX_TBUS_PERR_CNT_IDX: begin
				next_prdata = 32'(perr_cnt);
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
		if (next_pready && !addr_hit) begin
			next_pslverr = 1'b1;
		end
		// Data only in the answer cycle, so a stale decode never leaks out
		if (!next_pready || !addr_hit) begin
			next_prdata = 32'h0000_0000;
		end
		if (ev_parity && perr_cnt != '1) begin
			next_perr_cnt = perr_cnt + 1'b1;
		end
		if (wr_take && addr_hit) begin
			case (paddr[11:2])
				`RX_TBUS_CTRL_IDX: begin
					next_ctrl = wr_ctrl;
					if (wr_ctrl.aggregation && wr_ctrl.aps_enable) begin
						// Aggregation keeps the pins in telecom bus role
						next_ctrl.aps_enable = 1'b0;
						ev_aps_refused = 1'b1;
					end
				end
				`RX_TBUS_STATUS_IDX: begin
					w1c = pwdata[3:0];
				end
				`RX_TBUS_MASK_IDX: begin
					next_mask = pwdata[3:0];
				end
				`RX_TBUS_PERR_CNT_IDX: begin
					next_perr_cnt = '0;
				end
				default: begin
					next_mask = mask;
				end
			endcase
		end
		next_aps_role_active = next_ctrl.aps_enable;
	end

	// ======================================================================
	// Interrupt status
	always_comb begin
		events = 4'h0;
		events[`RX_TBUS_EV_PARITY_BIT] = ev_parity;
		events[`RX_TBUS_EV_AIS_BIT] = ev_ais;
		events[`RX_TBUS_EV_FRAME_BIT] = ev_frame;
		events[`RX_TBUS_EV_APS_REFUSED_BIT] = ev_aps_refused;
		// Set wins over a clear in the same cycle
		next_status = (status & ~w1c) | events;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl <= `RX_TBUS_CTRL_RESET;
			status <= `RX_TBUS_STATUS_RESET;
			mask <= `RX_TBUS_MASK_RESET;
			perr_cnt <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			aps_role_active <= 1'b0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			status <= next_status;
			mask <= next_mask;
			perr_cnt <= next_perr_cnt;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			aps_role_active <= next_aps_role_active;
			irq <= next_irq;
		end
	end

endmodule

// ==== rx_tbus_consts.svh ====
// Register map, field positions and reset values of the receive telecom bus input
`ifndef RX_TBUS_CONSTS_SVH
`define RX_TBUS_CONSTS_SVH

// ==========================================================================
// Register indexes (byte address is four times the index)
`define RX_TBUS_CTRL_IDX 10'h137
`define RX_TBUS_STATUS_IDX 10'h138
`define RX_TBUS_MASK_IDX 10'h139
`define RX_TBUS_AIS_IDX 10'h13A
`define RX_TBUS_BYTE_IDX 10'h13B
`define RX_TBUS_PERR_CNT_IDX 10'h13C

// ==========================================================================
// Control fields
`define RX_TBUS_CTRL_BUS_EN_BIT 0
`define RX_TBUS_CTRL_PAR_FULL_BIT 1
`define RX_TBUS_CTRL_PAR_ODD_BIT 2
`define RX_TBUS_CTRL_APS_EN_BIT 3
`define RX_TBUS_CTRL_AGGR_BIT 4
`define RX_TBUS_CTRL_WR_MASK 8'h1F

// ==========================================================================
// Status and mask fields
`define RX_TBUS_EV_PARITY_BIT 0
`define RX_TBUS_EV_AIS_BIT 1
`define RX_TBUS_EV_FRAME_BIT 2
`define RX_TBUS_EV_APS_REFUSED_BIT 3

// ==========================================================================
// Reset values and STS-1 count
`define RX_TBUS_CTRL_RESET 8'h00
`define RX_TBUS_STATUS_RESET 4'h0
`define RX_TBUS_MASK_RESET 4'h0
`define RX_TBUS_STS1_COUNT 2'h3

`endif

// ==== rx_tbus_pkg.sv ====
// Types shared by the receive telecom bus input
package rx_tbus_pkg;

	// ======================================================================
	// Link sample as seen at one falling edge of the bus clock
	typedef struct packed {
		logic [7:0] data;
		logic payload;
		logic marker;
		logic parity;
		logic alarm;
	} bus_sample_t;

	// ======================================================================
	// Control register layout
	typedef struct packed {
		logic [2:0] spare;
		logic aggregation;
		logic aps_enable;
		logic parity_odd;
		logic parity_full;
		logic bus_enable;
	} ctrl_t;

	// ======================================================================
	// Interleave alignment
	typedef enum logic [1:0] {
		ALIGN_HUNT = 2'b00,
		ALIGN_LOCKED = 2'b01
	} align_t;

endpackage

// ==== link_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module link_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] level
);

	// ======================================================================
	// Stages
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	// Level moves only while the last two stages agree
	always_comb begin
		next_level = (stage2 & stage3) | (level & (stage2 | stage3));
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
		end else begin
			stage1 <= raw;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
		end
	end

endmodule

// ==== bus_parity_check.sv ====
// Parity check of one telecom bus sample
`timescale 1ns/1ps
module bus_parity_check (
	input wire rx_tbus_pkg::bus_sample_t sample,
	input wire logic parity_full,
	input wire logic parity_odd,
	output logic mismatch
);

	// ======================================================================
	// Coverage and sense
	logic covered;

	always_comb begin
		covered = ^sample.data;
		if (parity_full) begin
			covered = covered ^ sample.payload ^ sample.marker;
		end
		// Even sense: all covered bits plus parity hold an even count of ones
		mismatch = covered ^ sample.parity ^ parity_odd;
	end

endmodule

// ==== rx_tbus_asserts.sv ====
// Port checks of the receive telecom bus input
`timescale 1ns/1ps
module rx_tbus_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] byte_out,
	input wire logic byte_strobe,
	input wire logic byte_is_payload,
	input wire logic byte_phase_marker,
	input wire logic [1:0] byte_sts1_index,
	input wire logic [2:0] ais_defect,
	input wire logic aps_role_active,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// ====
	// Bus cycle steps
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_access;
		psel && penable;
	endsequence
	sequence c1_byte;
		byte_strobe && byte_phase_marker && !byte_is_payload;
	endsequence
	chk_apb_wait: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_rdata_idle: assert property ((pslverr || prdata != 32'h0) |-> pready)
		else $error("read data or error outside answer cycle");
	chk_strobe_gap: assert property (byte_strobe |=> (!byte_strobe)[*5])
		else $error("byte strobes too close");
	chk_byte_hold: assert property (!byte_strobe |-> $stable(byte_out) &&
		$stable(byte_is_payload) && $stable(byte_phase_marker))
		else $error("byte outputs changed without strobe");
	chk_c1_index: assert property (c1_byte |-> byte_sts1_index == 2'h0)
		else $error("C1 byte not at index zero");
	chk_ais_moment: assert property ($changed(ais_defect) |->
		(byte_strobe && byte_is_payload) || ais_defect == 3'h0)
		else $error("ais changed without payload byte");
	chk_ais_which: assert property (byte_strobe && $changed(ais_defect) |->
		(ais_defect ^ $past(ais_defect)) == (3'h1 << byte_sts1_index))
		else $error("ais changed for wrong STS-1");
	chk_ais_ovh: assert property (byte_strobe && !byte_is_payload |-> $stable(ais_defect))
		else $error("overhead byte changed ais");
	chk_aps_idle: assert property (aps_role_active && $past(aps_role_active, 2) |->
		!byte_strobe && ais_defect == 3'h0)
		else $error("capture while payload APS role active");
	chk_irq_cause: assert property ($rose(irq) |-> byte_strobe || $past(pready))
		else $error("irq rose without cause");
endmodule
bind rx_telecom_bus_input rx_tbus_asserts u_rx_tbus_asserts (.clk_sys, .rst, .psel, .penable,
	.prdata, .pready, .pslverr, .byte_out, .byte_strobe, .byte_is_payload, .byte_phase_marker,
	.byte_sts1_index, .ais_defect, .aps_role_active, .irq);

// ==== tbus_source_model.sv ====
// Telecom bus source model driving the receive link pins
`timescale 1ns/1ps
module tbus_source_model (
	input wire logic par_full,
	input wire logic par_odd,
	output logic rx_bus_clock,
	output logic [7:0] rx_data_byte,
	output logic rx_payload_indicator,
	output logic rx_frame_phase_marker,
	output logic rx_bus_parity,
	output logic rx_alarm
);
	// ====
	// Idle pins, clock stands still low
	initial begin
		rx_bus_clock = 1'h0;
		rx_data_byte = 8'h00;
		rx_payload_indicator = 1'h0;
		rx_frame_phase_marker = 1'h0;
		rx_bus_parity = 1'h0;
		rx_alarm = 1'h0;
	end
	// ====
	// One byte per 800 ns period; offset keeps phase apart from clk_sys
	task automatic send_byte(input logic [7:0] d, input logic pl, mk, al, bad);
		#37;
		rx_data_byte = d;
		rx_payload_indicator = pl;
		rx_frame_phase_marker = mk;
		rx_alarm = al;
		rx_bus_parity = ^d ^ (par_full & (pl ^ mk)) ^ par_odd ^ bad;
		rx_bus_clock = 1'h1;
		#400;
		rx_bus_clock = 1'h0;
		#400;
		// Hold over: no stale value may pass for data
		rx_data_byte = ~d;
		rx_bus_parity = ~rx_bus_parity;
		rx_frame_phase_marker = 1'h0;
		rx_alarm = 1'h0;
	endtask
endmodule

// ==== rx_telecom_bus_input_tb_top.sv ====
// Testbench of the receive telecom bus input
`timescale 1ns/1ps
`include "rx_tbus_consts.svh"
module rx_telecom_bus_input_tb_top;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic par_full = 1'h0;
	logic par_odd = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, byte_strobe, byte_is_payload, byte_phase_marker, aps_role_active, irq;
	logic rx_bus_clock, rx_payload_indicator, rx_frame_phase_marker, rx_bus_parity, rx_alarm;
	logic [7:0] byte_out, rx_data_byte;
	logic [1:0] byte_sts1_index;
	logic [2:0] ais_defect;
	int fail_count = 0;
	int n_tests = 0;
	rx_telecom_bus_input u_rx_telecom_bus_input (.clk_sys, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_bus_clock, .rx_data_byte,
		.rx_payload_indicator, .rx_frame_phase_marker, .rx_bus_parity, .rx_alarm, .byte_out,
		.byte_strobe, .byte_is_payload, .byte_phase_marker, .byte_sts1_index, .ais_defect,
		.aps_role_active, .irq);
	tbus_source_model u_tbus_source_model (.par_full, .par_odd, .rx_bus_clock, .rx_data_byte,
		.rx_payload_indicator, .rx_frame_phase_marker, .rx_bus_parity, .rx_alarm);
	always #50 clk_sys = ~clk_sys;
	// ====
	// Shared tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		err = pslverr;
		check("pready", 32'h1, {31'h0, pready});
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, idx, d, r, e);
	endtask
	task automatic rd(input string what, input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'h0, idx, 32'h0, r, e);
		check(what, exp, r);
	endtask
	// Flags f: payload, marker, alarm, bad parity
	task automatic lbyte(input logic [7:0] d, input logic [3:0] f, input logic cap,
		input logic [1:0] idx);
		int n;
		n = 0;
		u_tbus_source_model.send_byte(d, f[3], f[2], f[1], f[0]);
		while (byte_strobe !== 1'h1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		check("captured", {31'h0, cap}, {31'h0, byte_strobe});
		if (cap) begin
			check("byte", {20'h0, idx, f[3:2], d},
				{20'h0, byte_sts1_index, byte_is_payload, byte_phase_marker, byte_out});
		end
	endtask
	// ====
	// Scenarios
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		rd("ctrl", `RX_TBUS_CTRL_IDX, 32'h0);
		rd("status", `RX_TBUS_STATUS_IDX, 32'h0);
		rd("mask", `RX_TBUS_MASK_IDX, 32'h0);
		rd("ais", `RX_TBUS_AIS_IDX, 32'h0);
		rd("perr", `RX_TBUS_PERR_CNT_IDX, 32'h0);
		apb(1'h0, 10'h140, 32'h0, r, e);
		check("unmapped", 32'h1, {31'h0, e});
		check("unmapped data", 32'h0, r);
		wr(`RX_TBUS_CTRL_IDX, 32'hFF);
		rd("ctrl refused", `RX_TBUS_CTRL_IDX, 32'h17);
		rd("status refused", `RX_TBUS_STATUS_IDX, 32'h8);
		wr(`RX_TBUS_STATUS_IDX, 32'hF);
		wr(`RX_TBUS_CTRL_IDX, 32'h9);
		repeat (2) @(negedge clk_sys);
		check("aps role", 32'h1, {31'h0, aps_role_active});
		lbyte(8'hA5, 4'h4, 1'h0, 2'h0);
	endtask
	task automatic t_par;
		for (int m = 0; m < 4; m++) begin
			par_full = m[0];
			par_odd = m[1];
			wr(`RX_TBUS_CTRL_IDX, 32'h1 | (m << 1));
			wr(`RX_TBUS_STATUS_IDX, 32'hF);
			wr(`RX_TBUS_PERR_CNT_IDX, 32'h0);
			lbyte(8'hA5, 4'h4, 1'h1, 2'h0);
			lbyte(8'h3C, 4'h8, 1'h1, 2'h1);
			lbyte(8'h81, 4'h9, 1'h1, 2'h2);
			rd("status parity", `RX_TBUS_STATUS_IDX, 32'h5);
			rd("perr count", `RX_TBUS_PERR_CNT_IDX, 32'h1);
			check("irq masked", 32'h0, {31'h0, irq});
		end
	endtask
	task automatic t_ais;
		par_full = 1'h0;
		par_odd = 1'h0;
		wr(`RX_TBUS_CTRL_IDX, 32'h1);
		wr(`RX_TBUS_MASK_IDX, 32'h2);
		wr(`RX_TBUS_STATUS_IDX, 32'hF);
		lbyte(8'hA5, 4'h4, 1'h1, 2'h0);
		lbyte(8'h11, 4'hA, 1'h1, 2'h1);
		check("ais set", 32'h2, {29'h0, ais_defect});
		lbyte(8'h22, 4'h2, 1'h1, 2'h2);
		check("ais overhead", 32'h2, {29'h0, ais_defect});
		repeat (2) @(negedge clk_sys);
		check("irq set", 32'h1, {31'h0, irq});
		lbyte(8'h33, 4'h8, 1'h1, 2'h0);
		lbyte(8'h44, 4'h8, 1'h1, 2'h1);
		lbyte(8'h5A, 4'hC, 1'h1, 2'h2);
		rd("ais reg", `RX_TBUS_AIS_IDX, 32'h0);
		rd("byte reg", `RX_TBUS_BYTE_IDX, 32'h1B5A);
		wr(`RX_TBUS_STATUS_IDX, 32'h2);
		repeat (3) @(negedge clk_sys);
		check("irq clear", 32'h0, {31'h0, irq});
		wr(`RX_TBUS_MASK_IDX, 32'h4);
		repeat (3) @(negedge clk_sys);
		check("irq unmask", 32'h1, {31'h0, irq});
	endtask
	// ====
	// Run and verdict
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'h0;
		t_regs();
		t_par();
		t_ais();
		end_of_test();
	end
	// Far beyond the roughly 35 us the scenarios need
	initial begin
		#1000000;
		fail_count++;
		end_of_test();
	end
endmodule
